// ---- rtl/bbr_defines.svh ----
// Address map constants and data values for the bit-band alias remapper
`ifndef BBR_DEFINES_SVH
`define BBR_DEFINES_SVH

// ----------------------------------------------------------------------
// Window bases
// ----------------------------------------------------------------------
`define BBR_SRAM_BAND_BASE 32'h2000_0000
`define BBR_SRAM_ALIAS_BASE 32'h2200_0000
`define BBR_PERI_BAND_BASE 32'h4000_0000
`define BBR_PERI_ALIAS_BASE 32'h4200_0000

// ----------------------------------------------------------------------
// Window geometry
// ----------------------------------------------------------------------
// Alias window is 32 MB: decode on address bits 31:25
`define BBR_ALIAS_DEC_LSB 25
// Bit-band region is 1 MB: byte offset is 20 bits wide
`define BBR_BAND_OFS_BITS 20
// Byte offset sits in alias bits 24:5, bit number in bits 4:2
`define BBR_OFS_LSB 5
`define BBR_BITNUM_LSB 2
`define BBR_BITNUM_BITS 3

// ----------------------------------------------------------------------
// Answer values
// ----------------------------------------------------------------------
`define BBR_BIT_CLEAR 32'h0000_0000
`define BBR_BIT_SET 32'h0000_0001

`endif

// ---- rtl/bbr_pkg.sv ----
// Types shared by the bit-band alias remapper
package bbr_pkg;

	// ------------------------------------------------------------------
	// Access size, kept unchanged across the remap
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		BBR_SZ_BYTE = 2'h0,
		BBR_SZ_HALF = 2'h1,
		BBR_SZ_WORD = 2'h2
	} bbr_size_t;

	// ------------------------------------------------------------------
	// Request from the core data bus
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		bbr_size_t size;
		logic write;
		logic fetch;
	} bbr_req_t;

	// ------------------------------------------------------------------
	// Command to the memory side
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		bbr_size_t size;
		logic write;
		logic lock;
	} bbr_cmd_t;

	// ------------------------------------------------------------------
	// Result of alias decoding
	// ------------------------------------------------------------------
	typedef struct packed {
		logic remap;
		logic fault;
		logic [31:0] addr;
		logic [4:0] bitpos;
	} bbr_map_t;

endpackage : bbr_pkg

// ---- rtl/bbr_remap.sv ----
// Bit-band alias remapper between the core data bus and memory side
`timescale 1ns/1ns
`include "bbr_defines.svh"

module bbr_remap
	import bbr_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic up_valid,
	input wire bbr_req_t up_req,
	output logic up_ready,
	output logic up_done,
	output logic [31:0] up_rdata,
	output logic up_err,
	output logic dn_valid,
	output bbr_cmd_t dn_cmd,
	input wire logic dn_ack,
	input wire logic [31:0] dn_rdata,
	input wire logic dn_err
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PASS,
		ST_BIT_RD,
		ST_BIT_WR
	} bbr_state_t;

	bbr_state_t state_reg, state_next;
	logic ready_reg, ready_next;
	logic done_reg, done_next;
	logic err_reg, err_next;
	logic [31:0] rdata_reg, rdata_next;
	logic dn_valid_reg, dn_valid_next;
	bbr_cmd_t cmd_reg, cmd_next;
	logic [4:0] bitpos_reg, bitpos_next;
	logic wbit_reg, wbit_next;
	logic is_wr_reg, is_wr_next;
	bbr_map_t map;
	logic [31:0] merged;

	// ------------------------------------------------------------------
	// Alias read answer
	// ------------------------------------------------------------------
	// The whole word reads as 0 or 1, whatever the other bits of the byte hold
	function automatic logic [31:0] bit_answer(input logic [31:0] word, input logic [4:0] pos);
		bit_answer = word[pos] ? `BBR_BIT_SET : `BBR_BIT_CLEAR;
	endfunction : bit_answer

	// ------------------------------------------------------------------
	// Alias decode
	// ------------------------------------------------------------------
	bbr_xlate u_xlate (
		.addr(up_req.addr),
		.size(up_req.size),
		.fetch(up_req.fetch),
		.map(map)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		ready_next = ready_reg;
		done_next = 1'b0;
		err_next = err_reg;
		rdata_next = rdata_reg;
		dn_valid_next = dn_valid_reg;
		cmd_next = cmd_reg;
		bitpos_next = bitpos_reg;
		wbit_next = wbit_reg;
		is_wr_next = is_wr_reg;
		merged = dn_rdata;
		merged[bitpos_reg] = wbit_reg;
		case (state_reg)
			ST_IDLE: begin
				if (up_valid && ready_reg) begin
					err_next = 1'b0;
					rdata_next = `BBR_BIT_CLEAR;
					if (map.fault) begin
						// Answered at once, nothing reaches memory
						done_next = 1'b1;
						err_next = 1'b1;
					end else if (map.remap) begin
						ready_next = 1'b0;
						dn_valid_next = 1'b1;
						cmd_next.addr = map.addr;
						cmd_next.wdata = up_req.wdata;
						cmd_next.size = up_req.size;
						cmd_next.write = 1'b0;
						cmd_next.lock = 1'b1;
						bitpos_next = map.bitpos;
						wbit_next = up_req.wdata[0];
						is_wr_next = up_req.write;
						state_next = ST_BIT_RD;
					end else begin
						// Bit-band regions and fetches in SRAM alias pass as is
						ready_next = 1'b0;
						dn_valid_next = 1'b1;
						cmd_next.addr = up_req.addr;
						cmd_next.wdata = up_req.wdata;
						cmd_next.size = up_req.size;
						cmd_next.write = up_req.write;
						cmd_next.lock = 1'b0;
						state_next = ST_PASS;
					end
				end
			end
			ST_PASS: begin
				if (dn_ack) begin
					dn_valid_next = 1'b0;
					done_next = 1'b1;
					ready_next = 1'b1;
					err_next = dn_err;
					rdata_next = dn_rdata;
					state_next = ST_IDLE;
				end
			end
			ST_BIT_RD: begin
				if (dn_ack) begin
					// A failed read phase drops the write so no guessed word reaches memory
					if (dn_err || !is_wr_reg) begin
						dn_valid_next = 1'b0;
						cmd_next.lock = 1'b0;
						done_next = 1'b1;
						ready_next = 1'b1;
						err_next = dn_err;
						// An error answer reads as clear rather than as a guess
						rdata_next = dn_err ? `BBR_BIT_CLEAR :
							bit_answer(dn_rdata, bitpos_reg);
						state_next = ST_IDLE;
					end else begin
						// Write phase follows with no idle cycle, lock held
						cmd_next.write = 1'b1;
						cmd_next.wdata = merged;
						state_next = ST_BIT_WR;
					end
				end
			end
			ST_BIT_WR: begin
				// Lock drops with the write acknowledge here; a read or failed read phase drops it at the read acknowledge
				if (dn_ack) begin
					dn_valid_next = 1'b0;
					cmd_next.lock = 1'b0;
					cmd_next.write = 1'b0;
					done_next = 1'b1;
					ready_next = 1'b1;
					err_next = dn_err;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				ready_next = 1'b1;
				dn_valid_next = 1'b0;
				cmd_next.lock = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= `BBR_BIT_CLEAR;
			dn_valid_reg <= 1'b0;
			cmd_reg <= '0;
			bitpos_reg <= 5'h00;
			wbit_reg <= 1'b0;
			is_wr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
			dn_valid_reg <= dn_valid_next;
			cmd_reg <= cmd_next;
			bitpos_reg <= bitpos_next;
			wbit_reg <= wbit_next;
			is_wr_reg <= is_wr_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Every output is a flip-flop, so the memory side never sees decode glitches
	assign up_ready = ready_reg;
	assign up_done = done_reg;
	assign up_err = err_reg;
	assign up_rdata = rdata_reg;
	assign dn_valid = dn_valid_reg;
	assign dn_cmd = cmd_reg;

endmodule : bbr_remap

// ---- rtl/bbr_xlate.sv ----
// Alias address decoder and translator for the bit-band remapper
`timescale 1ns/1ns
`include "bbr_defines.svh"

module bbr_xlate
	import bbr_pkg::*;
(
	input wire logic [31:0] addr,
	input wire bbr_size_t size,
	input wire logic fetch,
	output bbr_map_t map
);

	localparam int DL = `BBR_ALIAS_DEC_LSB;
	localparam logic [31:0] SRAM_AB = `BBR_SRAM_ALIAS_BASE;
	localparam logic [31:0] PERI_AB = `BBR_PERI_ALIAS_BASE;

	logic in_sram;
	logic in_peri;
	logic [`BBR_BAND_OFS_BITS-1:0] ofs;
	logic [`BBR_BITNUM_BITS-1:0] bitnum;
	logic [31:0] band_byte;

	always_comb begin
		in_sram = (addr[31:DL] == SRAM_AB[31:DL]);
		in_peri = (addr[31:DL] == PERI_AB[31:DL]);
		// Offset times 32 plus bit times 4, inverted
		ofs = addr[`BBR_OFS_LSB +: `BBR_BAND_OFS_BITS];
		bitnum = addr[`BBR_BITNUM_LSB +: `BBR_BITNUM_BITS];
		band_byte = (in_peri ? `BBR_PERI_BAND_BASE : `BBR_SRAM_BAND_BASE)
			| {12'h000, ofs};
		map.remap = (in_sram || in_peri) && !fetch;
		map.fault = in_peri && fetch;
		// Align the bit-band address to the access size so the size is kept
		case (size)
			BBR_SZ_WORD: map.addr = {band_byte[31:2], 2'b00};
			BBR_SZ_HALF: map.addr = {band_byte[31:1], 1'b0};
			default: map.addr = band_byte;
		endcase
		// Little-endian lane: byte lane times 8 plus bit number
		map.bitpos = {band_byte[1:0], bitnum};
	end

endmodule : bbr_xlate

// ---- verification/bbr_asserts.sv ----
// Port assertions for the bit-band alias remapper
`timescale 1ns/1ns
module bbr_asserts
	import bbr_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic up_valid,
	input wire bbr_req_t up_req,
	input wire logic up_ready,
	input wire logic up_done,
	input wire logic [31:0] up_rdata,
	input wire logic up_err,
	input wire logic dn_valid,
	input wire bbr_cmd_t dn_cmd,
	input wire logic dn_ack,
	input wire logic [31:0] dn_rdata,
	input wire logic dn_err
);
	logic take;
	logic alias_hit;
	logic [4:0] pos;
	bbr_req_t req_reg;
	logic [31:0] rd_reg;
	assign take = up_valid && up_ready;
	assign alias_hit = up_req.addr[31:25] == 7'h11 || up_req.addr[31:25] == 7'h21;
	assign pos = {req_reg.addr[6:5], req_reg.addr[4:2]};
	always_ff @(posedge core_clk) begin
		if (take) req_reg <= up_req;
		if (dn_valid && dn_ack) rd_reg <= dn_rdata;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_lock_rd;
		dn_valid && dn_ack && dn_cmd.lock && !dn_cmd.write && !dn_err;
	endsequence
	sequence s_lock_wr;
		dn_valid && dn_cmd.lock && dn_cmd.write;
	endsequence
	a_cmd_hold: assert property (dn_valid && !dn_ack |=> dn_valid && $stable(dn_cmd))
		else $error("command moved before ack");
	a_fetch_reject: assert property (take && up_req.fetch && up_req.addr[31:25] == 7'h21
		|=> up_done && up_err && !dn_valid) else $error("peripheral fetch not refused");
	a_size_kept: assert property (take && !up_req.fetch |=> dn_cmd.size == req_reg.size)
		else $error("access size changed");
	a_alias_map: assert property (take && !up_req.fetch && alias_hit |=> dn_valid
		&& dn_cmd.lock && !dn_cmd.write && dn_cmd.addr[19:2] == req_reg.addr[24:7]
		&& dn_cmd.addr[31:20] == (req_reg.addr[30] ? 12'h400 : 12'h200))
		else $error("alias address wrong");
	a_pass_thru: assert property (take && (!alias_hit || up_req.fetch && !up_req.addr[30])
		|=> dn_valid && !dn_cmd.lock && dn_cmd.addr == req_reg.addr)
		else $error("direct access altered");
	a_rmw_order: assert property (req_reg.write ##0 s_lock_rd |=> s_lock_wr)
		else $error("write phase missing");
	a_bit_merge: assert property (s_lock_wr |-> dn_cmd.wdata ==
		((rd_reg & ~(32'h0000_0001 << pos)) | ({31'h0, req_reg.wdata[0]} << pos)))
		else $error("merged word wrong");
	a_read_bit: assert property (!req_reg.write ##0 s_lock_rd |=> up_done
		&& up_rdata == {31'h0, rd_reg[pos]}) else $error("alias read value wrong");
endmodule : bbr_asserts

// ---- verification/bbr_mem_model.sv ----
// Memory-side model answering remapper commands
`timescale 1ns/1ns
module bbr_mem_model
	import bbr_pkg::*;
(
	input wire logic core_clk,
	input wire logic dn_valid,
	input wire bbr_cmd_t dn_cmd,
	input wire logic [3:0] lat,
	input wire logic err_on,
	output logic dn_ack,
	output logic [31:0] dn_rdata,
	output logic dn_err
);
	logic [31:0] mem [0:63];
	logic [3:0] cnt = 4'h0;
	logic [31:0] mask;
	logic [5:0] idx;
	assign idx = {dn_cmd.addr[30], dn_cmd.addr[6:2]};
	assign mask = dn_cmd.size == BBR_SZ_WORD ? 32'hFFFF_FFFF : dn_cmd.size == BBR_SZ_HALF ?
		32'h0000_FFFF << {dn_cmd.addr[1], 4'h0} : 32'h0000_00FF << {dn_cmd.addr[1:0], 3'h0};
	initial begin
		dn_ack = 1'b0;
		dn_err = 1'b0;
		dn_rdata = 32'h0000_0000;
		for (int i = 0; i < 64; i++) mem[i] = 32'h9E37_79B9 * i;
	end
	// Idle data toggles so a stale capture cannot pass
	always @(posedge core_clk) begin
		dn_ack <= 1'b0;
		dn_err <= 1'b0;
		dn_rdata <= ~dn_rdata;
		if (dn_valid && !dn_ack) begin
			if (cnt >= lat) begin
				cnt <= 4'h0;
				dn_ack <= 1'b1;
				dn_err <= err_on;
				dn_rdata <= mem[idx];
				if (dn_cmd.write && !err_on) mem[idx] <= (mem[idx] & ~mask) | (dn_cmd.wdata & mask);
			end else cnt <= cnt + 4'h1;
		end
	end
endmodule : bbr_mem_model

// ---- verification/testbench.sv ----
// Self-checking testbench for the bit-band alias remapper
`timescale 1ns/1ns
module testbench;
	import bbr_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic up_valid = 1'b0;
	bbr_req_t up_req = '0;
	logic up_ready, up_done, up_err, dn_valid, dn_ack, dn_err;
	logic [31:0] up_rdata, dn_rdata, rd, w0;
	bbr_cmd_t dn_cmd;
	logic [3:0] lat = 4'h0;
	logic err_on = 1'b0;
	logic er;
	int n_errors = 0;
	int total_checks = 0;
	always #25 core_clk = ~core_clk;
	bbr_remap dut_u (.core_clk(core_clk), .srst(srst), .up_valid(up_valid), .up_req(up_req),
		.up_ready(up_ready), .up_done(up_done), .up_rdata(up_rdata), .up_err(up_err),
		.dn_valid(dn_valid), .dn_cmd(dn_cmd), .dn_ack(dn_ack), .dn_rdata(dn_rdata), .dn_err(dn_err));
	bbr_mem_model mem_u (.core_clk(core_clk), .dn_valid(dn_valid), .dn_cmd(dn_cmd), .lat(lat),
		.err_on(err_on), .dn_ack(dn_ack), .dn_rdata(dn_rdata), .dn_err(dn_err));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic xfer(input logic [31:0] a, input logic [31:0] d, input bbr_size_t s,
		input logic w, input logic f);
		int n;
		n = 0;
		@(negedge core_clk);
		up_req = '{a, d, s, w, f};
		up_valid = 1'b1;
		// Ready is settled at the falling edge; the next rising edge takes the request
		while (up_ready !== 1'b1) @(negedge core_clk);
		@(negedge core_clk);
		up_valid = 1'b0;
		while (up_done !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		rd = up_rdata;
		er = up_err;
		chk("answer", 32'h0, 32'(n == 40));
	endtask : xfer
	task automatic t_sram_alias;
		logic [31:0] a;
		for (int b = 0; b < 8; b += 7) begin
			a = 32'h2200_0020 | {27'h0, 3'(b), 2'h0};
			w0 = mem_u.mem[0];
			xfer(a, 32'h0000_000F, BBR_SZ_WORD, 1'b1, 1'b0);
			chk("set word", w0 | (32'h1 << (8 + b)), mem_u.mem[0]);
			xfer(a, 32'h0, BBR_SZ_WORD, 1'b0, 1'b0);
			chk("read set", 32'h0000_0001, rd);
			chk("read err", 32'h0, 32'(er));
			xfer(a, 32'hFFFF_FFFE, BBR_SZ_WORD, 1'b1, 1'b0);
			chk("clear word", w0 & ~(32'h1 << (8 + b)), mem_u.mem[0]);
			xfer(a, 32'h0, BBR_SZ_WORD, 1'b0, 1'b0);
			chk("read clear", 32'h0000_0000, rd);
		end
	endtask : t_sram_alias
	task automatic t_peri_alias;
		lat = 4'h3;
		w0 = mem_u.mem[32];
		xfer(32'h4200_004C, 32'hFFFF_FFFE, BBR_SZ_HALF, 1'b1, 1'b0);
		chk("peri clear", w0 & 32'hFFF7_FFFF, mem_u.mem[32]);
		xfer(32'h4200_004C, 32'h0000_0000, BBR_SZ_HALF, 1'b0, 1'b0);
		chk("peri read", 32'h0000_0000, rd);
		xfer(32'h4200_004C, 32'h0000_0001, BBR_SZ_HALF, 1'b1, 1'b0);
		chk("peri half", w0 | 32'h0008_0000, mem_u.mem[32]);
		w0 = mem_u.mem[63];
		xfer(32'h43FF_FFFC, 32'h0000_00FE, BBR_SZ_BYTE, 1'b1, 1'b0);
		chk("top clear", w0 & 32'h7FFF_FFFF, mem_u.mem[63]);
		xfer(32'h43FF_FFFC, 32'h0000_0001, BBR_SZ_BYTE, 1'b1, 1'b0);
		chk("top bit", w0 | 32'h8000_0000, mem_u.mem[63]);
		lat = 4'h0;
	endtask : t_peri_alias
	task automatic t_direct;
		xfer(32'h4200_0000, 32'h0, BBR_SZ_WORD, 1'b0, 1'b1);
		chk("fetch err", 32'h1, 32'(er));
		xfer(32'h2200_0008, 32'h0, BBR_SZ_WORD, 1'b0, 1'b1);
		chk("sram fetch", mem_u.mem[2], rd);
		xfer(32'h2000_0008, 32'h1234_5678, BBR_SZ_WORD, 1'b1, 1'b0);
		chk("sram direct", 32'h1234_5678, mem_u.mem[2]);
		xfer(32'h4000_0005, 32'h0000_AB00, BBR_SZ_BYTE, 1'b1, 1'b0);
		chk("peri byte", 32'hAB, 32'(mem_u.mem[33][15:8]));
	endtask : t_direct
	task automatic t_err;
		err_on = 1'b1;
		w0 = mem_u.mem[0];
		xfer(32'h2200_0000, 32'h0000_0001, BBR_SZ_WORD, 1'b1, 1'b0);
		chk("rmw err", 32'h1, 32'(er));
		chk("no write", w0, mem_u.mem[0]);
		xfer(32'h2200_010C, 32'h0, BBR_SZ_WORD, 1'b0, 1'b0);
		chk("rd err val", 32'h0, rd);
		chk("rd err flag", 32'h1, 32'(er));
		xfer(32'h2000_0008, 32'h0, BBR_SZ_WORD, 1'b0, 1'b0);
		chk("pass err", 32'h1, 32'(er));
		err_on = 1'b0;
	endtask : t_err
	task automatic t_reset;
		w0 = mem_u.mem[0];
		lat = 4'h8;
		@(negedge core_clk);
		up_req = '{32'h2200_0000, 32'h0000_0001, BBR_SZ_WORD, 1'b1, 1'b0};
		up_valid = 1'b1;
		@(negedge core_clk);
		up_valid = 1'b0;
		srst = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("rst ready", 32'h1, 32'(up_ready));
		chk("rst valid", 32'h0, 32'(dn_valid));
		chk("rst lock", 32'h0, 32'(dn_cmd.lock));
		chk("rst done", 32'h0, 32'(up_done));
		srst = 1'b0;
		lat = 4'h0;
		repeat (12) @(negedge core_clk);
		chk("rst no write", w0, mem_u.mem[0]);
		xfer(32'h2200_010C, 32'h0, BBR_SZ_WORD, 1'b0, 1'b0);
		chk("rst read", 32'h0000_0001, rd);
	endtask : t_reset
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (2) @(negedge core_clk);
		srst = 1'b0;
		t_sram_alias();
		t_peri_alias();
		t_direct();
		t_err();
		t_reset();
		wrap_up();
	end
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
endmodule : testbench
bind bbr_remap bbr_asserts chk_u (.core_clk(core_clk), .srst(srst), .up_valid(up_valid),
	.up_req(up_req), .up_ready(up_ready), .up_done(up_done), .up_rdata(up_rdata), .up_err(up_err),
	.dn_valid(dn_valid), .dn_cmd(dn_cmd), .dn_ack(dn_ack), .dn_rdata(dn_rdata), .dn_err(dn_err));
